//--- logic/rtcnt_timer.sv
`timescale 1ns/10ps
module rtcnt_timer (
	// Clock and reset
	input  wire logic        ref_clk_in,
	input  wire logic        reset_n_in,
	// AXI4-Lite write
	input  wire logic [3:0]  s_awaddr_in,
	input  wire logic        s_awvalid_in,
	output logic             s_awready_out,
	input  wire logic [31:0] s_wdata_in,
	input  wire logic [3:0]  s_wstrb_in,
	input  wire logic        s_wvalid_in,
	output logic             s_wready_out,
	output logic [1:0]       s_bresp_out,
	output logic             s_bvalid_out,
	input  wire logic        s_bready_in,
	// AXI4-Lite read
	input  wire logic [3:0]  s_araddr_in,
	input  wire logic        s_arvalid_in,
	output logic             s_arready_out,
	output logic [31:0]      s_rdata_out,
	output logic [1:0]       s_rresp_out,
	output logic             s_rvalid_out,
	input  wire logic        s_rready_in,
	// Pins and neighbour events
	input  wire logic        channel_input_pin_in,
	input  wire logic        channel_output_pin_in,
	input  wire logic        subclock_in,
	input  wire logic        tb2_event_in,
	input  wire logic        prev_event_in,
	input  wire logic        next_event_in,
	// Outputs
	output logic             channel_output_pin_out,
	output logic             channel_output_oe_n_out,
	output logic             irq_req_out,
	output logic             wrap_event_out
);
	localparam int NSYNC = 6;

	rtcnt_pkg::rtcnt_mode_type mode_q;
	logic                      run_q;
	logic                      started_q;
	logic [15:0]               count_q;
	logic [15:0]               reload_q;
	logic [4:0]                div_q;
	logic [4:0]                sub_div_q;
	logic [NSYNC-1:0]          meta_q;
	logic [NSYNC-1:0]          sync_q;
	logic [NSYNC-1:0]          sync_old_q;
	logic [NSYNC-1:0]          raw_in;
	logic [NSYNC-1:0]          rise;
	logic [NSYNC-1:0]          fall;
	logic                      aw_hold_q;
	logic                      w_hold_q;
	logic [3:0]                awaddr_q;
	logic [31:0]               wdata_q;
	logic [3:0]                wstrb_q;
	logic                      wr_fire;
	logic                      wr_count;
	logic                      presc_tick;
	logic                      gate_ok;
	logic                      src_tick;
	logic                      count_up;
	logic                      cnt_en;
	logic                      underflow;
	logic                      overflow;
	logic                      wrap;
	logic [31:0]               rd_word;
	logic                      rd_hit;
	logic [31:0]               mode_wr;
	logic [31:0]               cnt_wr;

	assign raw_in = {next_event_in, prev_event_in, tb2_event_in,
		subclock_in, channel_output_pin_in, channel_input_pin_in};

	// Two flops on every outside input before use
	genvar g;
	generate
		for (g = 0; g < NSYNC; g++) begin : g_sync
			always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
				if (!reset_n_in) begin
					meta_q[g]     <= 1'b0;
					sync_q[g]     <= 1'b0;
					sync_old_q[g] <= 1'b0;
				end else begin
					meta_q[g]     <= raw_in[g];
					sync_q[g]     <= meta_q[g];
					sync_old_q[g] <= sync_q[g];
				end
			end
			assign rise[g] = sync_q[g] & ~sync_old_q[g];
			assign fall[g] = ~sync_q[g] & sync_old_q[g];
		end
	endgenerate

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return res;
	endfunction

	// Prescaler; the sub-clock is slow, so its edges are counted here
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			div_q     <= 5'h00;
			sub_div_q <= 5'h00;
		end else begin
			div_q <= div_q + 5'h01;
			if (rise[2]) begin
				sub_div_q <= sub_div_q + 5'h01;
			end
		end
	end

	always_comb begin
		unique case (mode_q.clk_sel)
			rtcnt_pkg::CLK_DIV1:  presc_tick = 1'b1;
			rtcnt_pkg::CLK_DIV2:
				presc_tick = div_q[0] == rtcnt_pkg::DIV2_LAST[0];
			rtcnt_pkg::CLK_DIV8:
				presc_tick = div_q[2:0] == rtcnt_pkg::DIV8_LAST[2:0];
			rtcnt_pkg::CLK_DIV32:
				presc_tick = div_q == rtcnt_pkg::DIV32_LAST;
			rtcnt_pkg::CLK_SUB32:
				presc_tick = rise[2] && sub_div_q == rtcnt_pkg::DIV32_LAST;
			default:              presc_tick = 1'b0;
		endcase
	end

	// Gate: count only while the input pin sits at the chosen level
	assign gate_ok = !mode_q.gate_en || (sync_q[0] == mode_q.edge_pol);

	always_comb begin
		unique case (mode_q.evt_src)
			rtcnt_pkg::SRC_PIN:
				src_tick = mode_q.edge_pol ? rise[0] : fall[0];
			rtcnt_pkg::SRC_TB2:  src_tick = rise[3];
			rtcnt_pkg::SRC_PREV: src_tick = rise[4];
			rtcnt_pkg::SRC_NEXT: src_tick = rise[5];
		endcase
	end

	assign count_up = (mode_q.op_mode == rtcnt_pkg::OPM_EVENT) &&
		(mode_q.dir_pin ? sync_q[1] : mode_q.dir_up);
	assign cnt_en = run_q && reload_q != 16'h0000 &&
		((mode_q.op_mode == rtcnt_pkg::OPM_TIMER && presc_tick &&
		gate_ok) || (mode_q.op_mode == rtcnt_pkg::OPM_EVENT &&
		src_tick));
	assign underflow = cnt_en && !count_up && count_q == 16'h0000;
	assign overflow  = cnt_en && count_up && count_q == 16'hffff;
	assign wrap = mode_q.free_run &&
		mode_q.op_mode == rtcnt_pkg::OPM_EVENT;

	// Register write path
	assign wr_fire  = aw_hold_q && w_hold_q && !s_bvalid_out;
	assign wr_count = wr_fire && awaddr_q == rtcnt_pkg::OFS_COUNT;
	// A function result cannot be sliced, so merged words get names
	assign mode_wr  = merge(32'(mode_q), wdata_q, wstrb_q);
	assign cnt_wr   = merge({16'h0000, reload_q}, wdata_q, wstrb_q);

	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			mode_q <= rtcnt_pkg::MODE_RST;
			run_q  <= 1'b0;
		end else if (wr_fire && awaddr_q == rtcnt_pkg::OFS_MODE) begin
			mode_q <= rtcnt_pkg::rtcnt_mode_type'(
				mode_wr[rtcnt_pkg::MODE_W-1:0]);
		end else if (wr_fire && awaddr_q == rtcnt_pkg::OFS_START &&
			wstrb_q[0]) begin
			run_q <= wdata_q[0];
		end
	end

	// First count clock marks the point after which writes hit reload only
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			started_q <= 1'b0;
		end else if (!run_q) begin
			started_q <= 1'b0;
		end else if (cnt_en) begin
			started_q <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			reload_q <= rtcnt_pkg::COUNT_RST;
		end else if (wr_count) begin
			reload_q <= cnt_wr[15:0];
		end
	end

	// Live counter; an early write overrides a count in the same cycle
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			count_q <= rtcnt_pkg::COUNT_RST;
		end else if (wr_count && (!run_q || !started_q)) begin
			count_q <= cnt_wr[15:0];
		end else if (underflow) begin
			count_q <= wrap ? 16'hffff : reload_q;
		end else if (overflow) begin
			count_q <= wrap ? 16'h0000 : reload_q;
		end else if (cnt_en) begin
			count_q <= count_up ? count_q + 16'h0001 : count_q - 16'h0001;
		end
	end

	// Outputs: request and neighbour pulse, toggling pin
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			irq_req_out            <= 1'b0;
			wrap_event_out         <= 1'b0;
			channel_output_pin_out <= 1'b0;
		end else begin
			irq_req_out    <= underflow || overflow;
			wrap_event_out <= underflow || overflow;
			if (!run_q) begin
				channel_output_pin_out <= 1'b0;
			end else if (mode_q.pulse_en && (underflow || overflow)) begin
				channel_output_pin_out <= !channel_output_pin_out;
			end
		end
	end

	// Pin is driven only as pulse output, never as direction input
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			channel_output_oe_n_out <= 1'b1;
		end else begin
			channel_output_oe_n_out <= !(mode_q.pulse_en &&
				!(mode_q.op_mode == rtcnt_pkg::OPM_EVENT &&
				mode_q.dir_pin));
		end
	end

	// AXI4-Lite write channels; address and data taken in either order
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			aw_hold_q     <= 1'b0;
			w_hold_q      <= 1'b0;
			awaddr_q      <= 4'h0;
			wdata_q       <= 32'h0000_0000;
			wstrb_q       <= 4'h0;
			s_awready_out <= 1'b1;
			s_wready_out  <= 1'b1;
			s_bvalid_out  <= 1'b0;
			s_bresp_out   <= rtcnt_pkg::RESP_OKAY;
		end else begin
			if (s_awvalid_in && s_awready_out) begin
				aw_hold_q     <= 1'b1;
				awaddr_q      <= {s_awaddr_in[3:2], 2'h0};
				s_awready_out <= 1'b0;
			end
			if (s_wvalid_in && s_wready_out) begin
				w_hold_q     <= 1'b1;
				wdata_q      <= s_wdata_in;
				wstrb_q      <= s_wstrb_in;
				s_wready_out <= 1'b0;
			end
			if (wr_fire) begin
				s_bvalid_out <= 1'b1;
				s_bresp_out  <= awaddr_q == rtcnt_pkg::OFS_STAT ?
					rtcnt_pkg::RESP_SLVERR : rtcnt_pkg::RESP_OKAY;
			end
			if (s_bvalid_out && s_bready_in) begin
				s_bvalid_out  <= 1'b0;
				aw_hold_q     <= 1'b0;
				w_hold_q      <= 1'b0;
				s_awready_out <= 1'b1;
				s_wready_out  <= 1'b1;
			end
		end
	end

	// Read decode
	always_comb begin
		rd_word = 32'h0000_0000;
		rd_hit  = 1'b1;
		unique case ({s_araddr_in[3:2], 2'h0})
			rtcnt_pkg::OFS_MODE:  rd_word = 32'(mode_q);
			rtcnt_pkg::OFS_START: rd_word = {31'h0, run_q};
			rtcnt_pkg::OFS_COUNT: rd_word = {16'h0000, count_q};
			rtcnt_pkg::OFS_STAT:  rd_word = {29'h0,
				channel_output_pin_out, started_q, run_q};
			default:              rd_hit  = 1'b0;
		endcase
	end

	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			s_arready_out <= 1'b1;
			s_rvalid_out  <= 1'b0;
			s_rdata_out   <= 32'h0000_0000;
			s_rresp_out   <= rtcnt_pkg::RESP_OKAY;
		end else if (s_arvalid_in && s_arready_out) begin
			s_arready_out <= 1'b0;
			s_rvalid_out  <= 1'b1;
			s_rdata_out   <= rd_word;
			s_rresp_out   <= rd_hit ? rtcnt_pkg::RESP_OKAY :
				rtcnt_pkg::RESP_SLVERR;
		end else if (s_rvalid_out && s_rready_in) begin
			s_rvalid_out  <= 1'b0;
			s_arready_out <= 1'b1;
		end
	end

	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!reset_n_in);

	sequence write_pair_s;
		aw_hold_q && w_hold_q && !s_bvalid_out;
	endsequence

	sequence count_write_s;
		write_pair_s ##0 awaddr_q == rtcnt_pkg::OFS_COUNT;
	endsequence

	uf_reload_a: assert property (
		(underflow && !wrap && !wr_count) |=> count_q == $past(reload_q))
		else $error("underflow did not reload");
	stop_hold_a: assert property (
		(!run_q && !wr_count) |=> $stable(count_q))
		else $error("count moved while stopped");
	early_wr_a: assert property (
		(count_write_s ##0 !started_q) |=> count_q == reload_q)
		else $error("early write missed counter");
	late_wr_a: assert property (
		(count_write_s ##0 (started_q && run_q && !cnt_en))
		|=> $stable(count_q))
		else $error("late write touched counter");
	out_low_a: assert property (
		!run_q |=> !channel_output_pin_out)
		else $error("output high while stopped");
	toggle_a: assert property (
		(run_q && mode_q.pulse_en && (underflow || overflow))
		|=> channel_output_pin_out != $past(channel_output_pin_out))
		else $error("output did not toggle");
	zero_quiet_a: assert property (
		(reload_q == 16'h0000) |=> !irq_req_out)
		else $error("request with zero value");
	free_wrap_a: assert property (
		(overflow && wrap && !wr_count) |=> count_q == 16'h0000)
		else $error("free-run overflow reloaded");
	irq_evt_a: assert property (
		(overflow || underflow) |=> irq_req_out ##1 !irq_req_out
		or (overflow || underflow))
		else $error("request not a pulse");
	read_cnt_a: assert property (
		(s_arvalid_in && s_arready_out &&
		s_araddr_in[3:2] == rtcnt_pkg::OFS_COUNT[3:2])
		|=> s_rvalid_out && s_rdata_out[15:0] == $past(count_q))
		else $error("read did not return count");
	bresp_a: assert property (
		write_pair_s |=> s_bvalid_out)
		else $error("write not answered");
endmodule

//--- logic/rtcnt_pkg.sv
package rtcnt_pkg;
	// Register byte offsets
	localparam logic [3:0] OFS_MODE  = 4'h0;
	localparam logic [3:0] OFS_START = 4'h4;
	localparam logic [3:0] OFS_COUNT = 4'h8;
	localparam logic [3:0] OFS_STAT  = 4'hc;
	localparam int         MODE_W    = 13;
	localparam int         CNT_W     = 16;
	// Values after reset
	localparam logic [MODE_W-1:0] MODE_RST  = 13'h0000;
	localparam logic [15:0]       COUNT_RST = 16'h0000;
	// Prescaler taps, counts of base ticks minus one
	localparam logic [4:0] DIV2_LAST  = 5'h01;
	localparam logic [4:0] DIV8_LAST  = 5'h07;
	localparam logic [4:0] DIV32_LAST = 5'h1f;
	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		OPM_TIMER = 2'h0,
		OPM_EVENT = 2'h1
	} rtcnt_opm_type;

	typedef enum logic [2:0] {
		CLK_DIV1  = 3'h0,
		CLK_DIV2  = 3'h1,
		CLK_DIV8  = 3'h2,
		CLK_DIV32 = 3'h3,
		CLK_SUB32 = 3'h4
	} rtcnt_clk_type;

	typedef enum logic [1:0] {
		SRC_PIN  = 2'h0,
		SRC_TB2  = 2'h1,
		SRC_PREV = 2'h2,
		SRC_NEXT = 2'h3
	} rtcnt_src_type;

	// Mode register layout, bit 0 upward from op_mode
	typedef struct packed {
		logic          dir_up;
		rtcnt_src_type evt_src;
		rtcnt_clk_type clk_sel;
		logic          free_run;
		logic          dir_pin;
		logic          gate_en;
		logic          edge_pol;
		logic          pulse_en;
		rtcnt_opm_type op_mode;
	} rtcnt_mode_type;
endpackage

//--- bench/rtcnt_pins.sv
`timescale 1ns/10ps
// Outside world of one channel: count pin, shared pin, neighbour lines
module rtcnt_pins (
	// Clock
	input  wire logic       ref_clk_in,
	// Bench commands
	input  wire logic [4:0] kick_in,
	input  wire logic       gate_lvl_in,
	input  wire logic       dir_lvl_in,
	// Device drive of the shared pin
	input  wire logic       pin_drv_in,
	input  wire logic       oe_n_in,
	// Lines to the channel
	output logic            in_pin_out,
	output logic            out_pin_out,
	output logic [3:0]      evt_out
);
	logic [4:0] s1_q = 5'h00;
	logic [4:0] s2_q = 5'h00;

	// Two cycles high per kick, so no edge is lost to the synchroniser
	always_ff @(posedge ref_clk_in) begin
		s1_q <= kick_in;
		s2_q <= s1_q;
	end
	assign in_pin_out = gate_lvl_in ^ (s1_q[0] | s2_q[0]);
	assign evt_out    = s1_q[4:1] | s2_q[4:1];
	// Device level while it drives, else the direction level from outside
	assign out_pin_out = oe_n_in ? dir_lvl_in : pin_drv_in;
endmodule

//--- bench/rtcnt_timer_tb.sv
`timescale 1ns/10ps
module rtcnt_timer_tb;
	typedef struct packed {
		logic [15:0] mode;
		logic [15:0] rel;
		logic [2:0]  src;
		logic [7:0]  n;
		logic        dir;
		logic [15:0] exp;
	} rtcnt_row_type;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [3:0]  awa = 4'h0;
	logic        awv = 1'b0;
	logic [31:0] wd = 32'h0;
	logic        wv = 1'b0;
	logic        br = 1'b0;
	logic [3:0]  ara = 4'h0;
	logic        arv = 1'b0;
	logic        rr = 1'b0;
	logic [4:0]  kick = 5'h00;
	logic        gate = 1'b0;
	logic        dir = 1'b0;
	logic        awr, wr, bv, arr, rv, pin_in, opin, pin_o, oe_n, irq;
	logic [1:0]  bresp, rresp;
	logic [31:0] rd;
	logic [3:0]  evt;
	logic        wrp;
	int          error_cnt = 0;
	int          num_checks = 0;
	int          cyc = 0;
	// Sub-clock row first: its prescaler phase is still at zero
	rtcnt_row_type rows [8] = '{
		'{16'h0200, 16'h0005, 3'h4, 8'd64, 1'b0, 16'h0003},
		'{16'h0009, 16'h000a, 3'h0, 8'd3, 1'b0, 16'h0007},
		'{16'h0001, 16'h000a, 3'h0, 8'd3, 1'b0, 16'h0007},
		'{16'h1401, 16'h000a, 3'h1, 8'd3, 1'b0, 16'h000d},
		'{16'h0801, 16'h000a, 3'h2, 8'd2, 1'b0, 16'h0008},
		'{16'h1c01, 16'hfffe, 3'h3, 8'd2, 1'b0, 16'hfffe},
		'{16'h1c41, 16'hfffe, 3'h3, 8'd2, 1'b0, 16'h0000},
		'{16'h0421, 16'h000a, 3'h1, 8'd2, 1'b1, 16'h000c}};

	initial forever #2.5 clk = ~clk;

	rtcnt_timer u_rtcnt_timer (
		.ref_clk_in(clk), .reset_n_in(rst_n),
		.s_awaddr_in(awa), .s_awvalid_in(awv), .s_awready_out(awr),
		.s_wdata_in(wd), .s_wstrb_in(4'hf), .s_wvalid_in(wv),
		.s_wready_out(wr), .s_bresp_out(bresp), .s_bvalid_out(bv),
		.s_bready_in(br), .s_araddr_in(ara), .s_arvalid_in(arv),
		.s_arready_out(arr), .s_rdata_out(rd), .s_rresp_out(rresp),
		.s_rvalid_out(rv), .s_rready_in(rr),
		.channel_input_pin_in(pin_in), .channel_output_pin_in(opin),
		.subclock_in(evt[3]), .tb2_event_in(evt[0]),
		.prev_event_in(evt[1]), .next_event_in(evt[2]),
		.channel_output_pin_out(pin_o), .channel_output_oe_n_out(oe_n),
		.irq_req_out(irq), .wrap_event_out(wrp));

	rtcnt_pins u_rtcnt_pins (
		.ref_clk_in(clk), .kick_in(kick), .gate_lvl_in(gate),
		.dir_lvl_in(dir), .pin_drv_in(pin_o), .oe_n_in(oe_n),
		.in_pin_out(pin_in), .out_pin_out(opin), .evt_out(evt));

	task automatic end_sim();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic axw(input logic [3:0] a, input logic [31:0] d,
			output logic [1:0] r);
		@(posedge clk);
		awa <= a;
		wd  <= d;
		awv <= 1'b1;
		wv  <= 1'b1;
		br  <= 1'b1;
		do begin
			@(posedge clk);
			if (awv && awr)
				awv <= 1'b0;
			if (wv && wr)
				wv <= 1'b0;
		end while (bv !== 1'b1);
		r = bresp;
		br <= 1'b0;
	endtask

	task automatic axr(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rr  <= 1'b1;
		do begin
			@(posedge clk);
			if (arv && arr)
				arv <= 1'b0;
		end while (rv !== 1'b1);
		d = rd;
		chk({30'h0, rresp}, {30'h0, rtcnt_pkg::RESP_OKAY});
		rr <= 1'b0;
	endtask

	task automatic pulse(input int idx, input int n);
		repeat (n) begin
			@(posedge clk);
			kick <= 5'h01 << idx;
			@(posedge clk);
			kick <= 5'h00;
			repeat (3) @(posedge clk);
		end
		repeat (6) @(posedge clk);
	endtask

	task automatic wait_irq();
		do @(posedge clk); while (irq !== 1'b1);
	endtask

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 8000) begin
			error_cnt++;
			end_sim();
		end
	end

	initial begin
		logic [1:0]  r;
		logic [31:0] d;
		logic [31:0] e;
		int          t;
		logic        lv;
		logic        seen;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		chk({30'h0, oe_n, pin_o}, 32'h2);
		axr(rtcnt_pkg::OFS_MODE, d);
		chk(d, 32'h0);
		axr(rtcnt_pkg::OFS_COUNT, d);
		chk(d, 32'h0);
		// Status is read-only; a write is refused and changes nothing
		axw(rtcnt_pkg::OFS_STAT, 32'h7, r);
		chk({30'h0, r}, {30'h0, rtcnt_pkg::RESP_SLVERR});
		axr(rtcnt_pkg::OFS_STAT, d);
		chk(d, 32'h0);
		foreach (rows[i]) begin
			axw(rtcnt_pkg::OFS_MODE, {16'h0, rows[i].mode}, r);
			axw(rtcnt_pkg::OFS_COUNT, {16'h0, rows[i].rel}, r);
			dir <= rows[i].dir;
			axw(rtcnt_pkg::OFS_START, 32'h1, r);
			pulse(rows[i].src, rows[i].n);
			axr(rtcnt_pkg::OFS_COUNT, d);
			chk(d, {16'h0, rows[i].exp});
			axw(rtcnt_pkg::OFS_START, 32'h0, r);
			pulse(rows[i].src, 1);
			axr(rtcnt_pkg::OFS_COUNT, d);
			chk(d, {16'h0, rows[i].exp});
		end
		dir <= 1'b0;
		// Timer on the undivided clock with pulse output
		axw(rtcnt_pkg::OFS_MODE, 32'h4, r);
		// Enable follows the mode one edge later
		@(posedge clk);
		chk({31'h0, oe_n}, 32'h0);
		axw(rtcnt_pkg::OFS_COUNT, 32'h2, r);
		axw(rtcnt_pkg::OFS_START, 32'h1, r);
		axr(rtcnt_pkg::OFS_STAT, d);
		chk({31'h0, d[0]}, 32'h1);
		wait_irq();
		lv = pin_o;
		t = 0;
		do begin
			@(posedge clk);
			t++;
		end while (irq !== 1'b1);
		chk(t, 32'd3);
		chk({31'h0, wrp}, 32'h1);
		chk({31'h0, pin_o}, {31'h0, ~lv});
		// Running write reaches the counter only at a later reload
		axw(rtcnt_pkg::OFS_COUNT, 32'h4, r);
		wait_irq();
		wait_irq();
		t = 0;
		do begin
			@(posedge clk);
			t++;
		end while (irq !== 1'b1);
		chk(t, 32'd5);
		axw(rtcnt_pkg::OFS_START, 32'h0, r);
		repeat (3) @(posedge clk);
		chk({31'h0, pin_o}, 32'h0);
		// Zero value: no count, no request, no pulse
		axw(rtcnt_pkg::OFS_COUNT, 32'h0, r);
		axw(rtcnt_pkg::OFS_START, 32'h1, r);
		seen = 1'b0;
		repeat (20) begin
			@(posedge clk);
			seen = seen | irq | pin_o | wrp;
		end
		chk({31'h0, seen}, 32'h0);
		axw(rtcnt_pkg::OFS_START, 32'h0, r);
		// Gate holds the count while the pin sits at the idle level
		axw(rtcnt_pkg::OFS_MODE, 32'h18, r);
		axw(rtcnt_pkg::OFS_COUNT, 32'd100, r);
		axw(rtcnt_pkg::OFS_START, 32'h1, r);
		repeat (10) @(posedge clk);
		axr(rtcnt_pkg::OFS_COUNT, d);
		chk(d, 32'd100);
		gate <= 1'b1;
		repeat (10) @(posedge clk);
		axr(rtcnt_pkg::OFS_COUNT, d);
		chk({31'h0, d[15:0] < 16'd100}, 32'h1);
		// Paused after the first count: a write reaches reload only
		gate <= 1'b0;
		repeat (4) @(posedge clk);
		axr(rtcnt_pkg::OFS_COUNT, e);
		axw(rtcnt_pkg::OFS_COUNT, 32'd50, r);
		axr(rtcnt_pkg::OFS_COUNT, d);
		chk(d, e);
		gate <= 1'b1;
		wait_irq();
		axr(rtcnt_pkg::OFS_COUNT, d);
		chk({31'h0, d[15:0] <= 16'd50 && d[15:0] > 16'd40}, 32'h1);
		axw(rtcnt_pkg::OFS_START, 32'h0, r);
		// Divided clocks: reload 1 gives two ticks per period
		for (int k = 1; k < 4; k++) begin
			axw(rtcnt_pkg::OFS_MODE, 32'(k) << 7, r);
			axw(rtcnt_pkg::OFS_COUNT, 32'h1, r);
			axw(rtcnt_pkg::OFS_START, 32'h1, r);
			wait_irq();
			t = 0;
			do begin
				@(posedge clk);
				t++;
			end while (irq !== 1'b1);
			chk(t, k == 1 ? 32'd4 : k == 2 ? 32'd16 : 32'd64);
			axw(rtcnt_pkg::OFS_START, 32'h0, r);
		end
		end_sim();
	end
endmodule
